// ===== design/astrc_pkg.sv
// Shared constants and types for the asynchronous serial transmit and receive core.
// Assumes a single clock domain and an APB register port with 32-bit data.
`default_nettype none

package astrc_pkg;

  // Register byte addresses on the APB port.
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_CTRL3 = 8'h08;
  localparam logic [7:0] ADDR_STAT1 = 8'h0c;
  localparam logic [7:0] ADDR_STAT2 = 8'h10;
  localparam logic [7:0] ADDR_DATA = 8'h14;
  localparam logic [7:0] ADDR_BAUD = 8'h18;

  // Field positions.
  localparam int C1_PORT_EN = 6;
  localparam int C1_TX_INV = 5;
  localparam int C1_CHAR9 = 4;
  localparam int C2_TXE_IE = 7;
  localparam int C2_TXD_IE = 6;
  localparam int C2_RXF_IE = 5;
  localparam int C2_TX_EN = 3;
  localparam int C2_RX_EN = 2;
  localparam int C2_BREAK = 0;
  localparam int C3_RX9 = 7;
  localparam int C3_TX9 = 6;
  localparam int S1_TXE = 7;
  localparam int S1_TXD = 6;
  localparam int S1_RXF = 5;
  localparam int S1_NF = 2;
  localparam int S1_FE = 1;
  localparam int S2_BRK = 1;
  localparam int S2_BUSY = 0;
  localparam int BAUD_SRC = 16;

  // Reset value of the oversample divider.
  localparam logic [15:0] BAUD_DIV_RST = 16'h0001;

  // Frame lengths in bit times and receive counts.
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] FRAME8 = 4'ha;
  localparam logic [3:0] FRAME9 = 4'hb;
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;

  // Oversample tick positions within one bit.
  localparam logic [4:0] RT1 = 5'h01;
  localparam logic [4:0] RT3 = 5'h03;
  localparam logic [4:0] RT5 = 5'h05;
  localparam logic [4:0] RT7 = 5'h07;
  localparam logic [4:0] RT8 = 5'h08;
  localparam logic [4:0] RT9 = 5'h09;
  localparam logic [4:0] RT10 = 5'h0a;
  localparam logic [4:0] RT_RESYNC = 5'h0c;
  localparam logic [4:0] RT16 = 5'h10;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PRE = 2'b01,
    TX_DATA = 2'b10,
    TX_BRK = 2'b11
  } astrc_tx_st_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } astrc_rx_st_t;

endpackage : astrc_pkg

`default_nettype wire

// ===== design/astrc_baud.sv
// Oversample tick generator: one pulse per oversample period, sixteen per bit.
// Assumes the external baud source is asynchronous and slower than clock_i / 4.
`default_nettype none

module astrc_baud
  import astrc_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic src_sel_i,
  input wire logic ext_clk_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);

  logic s1_r, s2_r, s3_r;
  logic [DIV_W-1:0] cnt_r;

  // The external source passes two flops; the third only feeds edge detection.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce_i) begin
      s1_r <= ext_clk_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Internal divider; a divisor of zero behaves as one so the tick never stops.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (src_sel_i) begin
        cnt_r <= '0;
        tick_o <= s2_r & !s3_r;
      end else if (cnt_r + 1'b1 >= div_i) begin
        cnt_r <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
        tick_o <= 1'b0;
      end
    end
  end

endmodule : astrc_baud

`default_nettype wire

// ===== design/astrc_rx.sv
// Receiver: start search, start verification, majority-vote data and stop recovery.
// Assumes tick_i is a one-cycle oversample pulse at sixteen times the baud rate.
`default_nettype none

module astrc_rx
  import astrc_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic char9_i,
  input wire logic rx_pin_i,
  output logic done_o,
  output logic [7:0] data_o,
  output logic ninth_o,
  output logic fe_o,
  output logic nf_o,
  output logic brk_o,
  output logic busy_o
);

  astrc_rx_st_t st_r;
  logic sy1_r, sy2_r, last_r, nf_r, prev_r, edge_r, allz_r;
  logic [2:0] hist_r, samp_r;
  logic [4:0] rt_r, edge_rt_r;
  logic [3:0] idx_r;
  logic [8:0] dat_r;
  logic [2:0] win;
  logic vote, split;

  // Three samples: two held, one live; majority and disagreement.
  assign win = {samp_r[1:0], sy2_r};
  assign vote = (win[0] & win[1]) | (win[0] & win[2]) | (win[1] & win[2]);
  assign split = (win != 3'h0) && (win != 3'h7);
  assign busy_o = (st_r != RX_HUNT);

  // Pin synchroniser.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sy1_r <= 1'b1;
      sy2_r <= 1'b1;
    end else if (ce_i) begin
      sy1_r <= rx_pin_i;
      sy2_r <= sy1_r;
    end
  end

  // Receive sequencer, advanced once per oversample tick.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= RX_HUNT;
      hist_r <= 3'h0;
      samp_r <= 3'h0;
      rt_r <= RT1;
      edge_rt_r <= RT1;
      idx_r <= 4'h0;
      dat_r <= 9'h000;
      {last_r, nf_r, prev_r, edge_r, allz_r} <= 5'h00;
      {done_o, data_o, ninth_o, fe_o, nf_o, brk_o} <= 13'h0000;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (!en_i) begin
        st_r <= RX_HUNT;
        hist_r <= 3'h0;
      end else if (tick_i) begin
        last_r <= sy2_r;
        rt_r <= (rt_r == RT16) ? RT1 : rt_r + RT1;
        if (rt_r == RT3 || rt_r == RT5 || rt_r == RT8 || rt_r == RT9) begin
          samp_r <= {samp_r[1:0], sy2_r};
        end
        case (st_r)
          RX_HUNT: begin
            hist_r <= {hist_r[1:0], sy2_r};
            if (!sy2_r && hist_r == 3'h7) begin
              st_r <= RX_START;
              rt_r <= RT1 + RT1;
              nf_r <= 1'b0;
            end else begin
              rt_r <= RT1;
            end
          end
          RX_START: begin
            if (rt_r == RT7) begin
              if (vote) begin
                st_r <= RX_HUNT;
                hist_r <= 3'h0;
                rt_r <= RT1;
              end else if (win != 3'h0) begin
                nf_r <= 1'b1;
              end
            end
            if (rt_r == RT10 && win != 3'h0) begin
              nf_r <= 1'b1;
            end
            if (rt_r == RT16) begin
              st_r <= RX_BITS;
              idx_r <= 4'h0;
              prev_r <= 1'b0;
              edge_r <= 1'b0;
              allz_r <= 1'b1;
            end
          end
          RX_BITS: begin
            // A falling edge early in the bit is remembered for resynchronisation.
            if (!edge_r && last_r && !sy2_r && rt_r <= RT7) begin
              edge_r <= 1'b1;
              edge_rt_r <= rt_r;
            end
            if (rt_r == RT10) begin
              edge_r <= 1'b0;
              if (idx_r == (char9_i ? BITS9 : BITS8)) begin
                st_r <= RX_HUNT;
                hist_r <= 3'h0;
                done_o <= 1'b1;
                fe_o <= !vote;
                nf_o <= nf_r | split;
                brk_o <= allz_r & !vote;
                // A break leaves zero data and a zero ninth bit.
                data_o <= (allz_r & !vote) ? 8'h00 : dat_r[7:0];
                ninth_o <= (allz_r & !vote) ? 1'b0 :
                           (char9_i ? dat_r[8] : dat_r[7]);
              end else begin
                dat_r[idx_r] <= vote;
                nf_r <= nf_r | split;
                allz_r <= allz_r & !vote;
                prev_r <= vote;
                idx_r <= idx_r + 4'h1;
                if (prev_r && !vote && edge_r) begin
                  rt_r <= RT_RESYNC - edge_rt_r;
                end
              end
            end
          end
          default: st_r <= RX_HUNT;
        endcase
      end
    end
  end

endmodule : astrc_rx

`default_nettype wire

// ===== design/astrc_core.sv
// Asynchronous serial transmit and receive core with an APB register port.
// Assumes APB from logic on clock_i; rx_pin_i and baud_ext_i are asynchronous pins.
// Summary of operation
// - Length select picks 8 or 9 data bits; ninth transmit bit supplies bit 8.
// - Received ninth bit holds bit 8, or a copy of bit 7 in 8-bit mode.
// - Transmit-empty clears only when a status-one read precedes a data write.
// - Transmission opens with a preamble; data framed by start 0 and stop 1.
// - Transmit-empty sets on load into shift register; raises interrupt when enabled.
// - Transmit pin rests at one, or at zero when inverted, whenever no character is shifting.
// - Clearing port enable releases both pins at once.
// - Send-break repeats zero characters; after clearing, at least one 1 follows (only when no data is waiting; waiting data starts at once).
// - Break detected when data bits and stop position are all zero.
// - Break sets framing, full and break flags; clears data and ninth bit.
// - Idle character is all ones, length by length select; preamble is one.
// - Enable cleared mid-character finishes it; toggling enable queues an idle.
// - Invert bit flips every transmitted level including idle and break.
// - Transmit-done shows everything empty and idle; raises interrupt when enabled.
// - Completed character goes to data buffer, sets full, interrupts when enabled.
// - Receiver samples at sixteen times the baud rate.
// - Oversample count resyncs after start bit and on 1-to-0 data changes.
// - Start search looks for zero after three ones, then counts to sixteen.
// - Start verified by ticks 3, 5, 7; two ones fail; one one is noise.
// - Failed verification resets the count and restarts the search.
// - Data bit is majority of ticks 8, 9, 10; disagreement flags noise.
// - Stop bit majority zero is a framing error; disagreement flags noise.
// - Start samples at ticks 8 to 10 only flag noise, never reject.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`default_nettype none

module astrc_core
  import astrc_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_pin_i,
  input wire logic baud_ext_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o,
  output logic rx_pin_claim_o,
  output logic tx_irq_o,
  output logic rx_irq_o
);

  // The divider and its register must fit the reset value and bus word.
  if (DIV_W < 4 || DIV_W > 16) begin : g_chk
    $error("astrc_core: DIV_W must lie between 4 and 16");
  end

  // Control state.
  logic port_en_r, tx_inv_r, char9_r;
  logic txe_ie_r, txd_ie_r, rxf_ie_r, tx_en_r, rx_en_r, brk_r;
  logic tx9_r, baud_src_r;
  logic [DIV_W-1:0] baud_div_r;

  // Status and data state.
  logic txe_r, txd_r, rxf_r, nf_r, fe_r, bkf_r;
  logic tx_arm_r, rx_arm_r;
  logic [7:0] txbuf_r, rxdata_r;
  logic rx9_r;

  // Transmitter state.
  astrc_tx_st_t tx_st_r;
  astrc_tx_st_t tx_pick;
  logic [3:0] sub_r, bit_r;
  logic [10:0] sh_r;
  logic qidle_r, te_prev_r;

  // Bus and submodule wires.
  logic acc_w, fin_w, wr_w, rd_w, hit_w;
  logic [31:0] rd_v;
  logic os_tick;
  logic rx_done, rx_ninth, rx_fe, rx_nf, rx_brk, rx_busy;
  logic [7:0] rx_data;
  logic bit_end, char_end, launch, te_rise;
  logic [3:0] frame_len;

  // APB phases: a one-cycle wait gives pready a registered source.
  assign acc_w = psel_i & penable_i & !pready_o;
  assign fin_w = psel_i & penable_i & pready_o;
  assign wr_w = fin_w & pwrite_i;
  assign rd_w = fin_w & !pwrite_i;

  // Read mux and address decode.
  always_comb begin
    rd_v = 32'h0000_0000;
    hit_w = 1'b1;
    if (paddr_i == ADDR_CTRL1) begin
      rd_v[C1_PORT_EN] = port_en_r;
      rd_v[C1_TX_INV] = tx_inv_r;
      rd_v[C1_CHAR9] = char9_r;
    end else if (paddr_i == ADDR_CTRL2) begin
      rd_v[C2_TXE_IE] = txe_ie_r;
      rd_v[C2_TXD_IE] = txd_ie_r;
      rd_v[C2_RXF_IE] = rxf_ie_r;
      rd_v[C2_TX_EN] = tx_en_r;
      rd_v[C2_RX_EN] = rx_en_r;
      rd_v[C2_BREAK] = brk_r;
    end else if (paddr_i == ADDR_CTRL3) begin
      rd_v[C3_RX9] = rx9_r;
      rd_v[C3_TX9] = tx9_r;
    end else if (paddr_i == ADDR_STAT1) begin
      rd_v[S1_TXE] = txe_r;
      rd_v[S1_TXD] = txd_r;
      rd_v[S1_RXF] = rxf_r;
      rd_v[S1_NF] = nf_r;
      rd_v[S1_FE] = fe_r;
    end else if (paddr_i == ADDR_STAT2) begin
      rd_v[S2_BRK] = bkf_r;
      rd_v[S2_BUSY] = rx_busy;
    end else if (paddr_i == ADDR_DATA) begin
      rd_v[7:0] = rxdata_r;
    end else if (paddr_i == ADDR_BAUD) begin
      rd_v[DIV_W-1:0] = baud_div_r;
      rd_v[BAUD_SRC] = baud_src_r;
    end else begin
      hit_w = 1'b0;
    end
  end

  // Bus answer: data and error are captured one cycle before completion.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_o <= acc_w;
      pslverr_o <= acc_w & !hit_w;
      if (acc_w) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_v;
      end
    end
  end

  // Software-written control bits.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {port_en_r, tx_inv_r, char9_r} <= 3'h0;
      {txe_ie_r, txd_ie_r, rxf_ie_r} <= 3'h0;
      {tx_en_r, rx_en_r, brk_r, tx9_r, baud_src_r} <= 5'h00;
      baud_div_r <= BAUD_DIV_RST[DIV_W-1:0];
      txbuf_r <= 8'h00;
    end else if (ce_i && wr_w) begin
      if (paddr_i == ADDR_CTRL1) begin
        port_en_r <= pwdata_i[C1_PORT_EN];
        tx_inv_r <= pwdata_i[C1_TX_INV];
        char9_r <= pwdata_i[C1_CHAR9];
      end else if (paddr_i == ADDR_CTRL2) begin
        txe_ie_r <= pwdata_i[C2_TXE_IE];
        txd_ie_r <= pwdata_i[C2_TXD_IE];
        rxf_ie_r <= pwdata_i[C2_RXF_IE];
        tx_en_r <= pwdata_i[C2_TX_EN];
        rx_en_r <= pwdata_i[C2_RX_EN];
        brk_r <= pwdata_i[C2_BREAK];
      end else if (paddr_i == ADDR_CTRL3) begin
        tx9_r <= pwdata_i[C3_TX9];
      end else if (paddr_i == ADDR_DATA) begin
        txbuf_r <= pwdata_i[7:0];
      end else if (paddr_i == ADDR_BAUD) begin
        baud_div_r <= pwdata_i[DIV_W-1:0];
        baud_src_r <= pwdata_i[BAUD_SRC];
      end
    end
  end

  // Oversample clock, shared by both directions.
  astrc_baud #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .src_sel_i(baud_src_r),
    .ext_clk_i(baud_ext_i),
    .div_i(baud_div_r),
    .tick_o(os_tick)
  );

  // Receiver; it is held in search while the port or receiver is off.
  astrc_rx u_rx (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .en_i(port_en_r & rx_en_r),
    .tick_i(os_tick),
    .char9_i(char9_r),
    .rx_pin_i(rx_pin_i),
    .done_o(rx_done),
    .data_o(rx_data),
    .ninth_o(rx_ninth),
    .fe_o(rx_fe),
    .nf_o(rx_nf),
    .brk_o(rx_brk),
    .busy_o(rx_busy)
  );

  // Receive buffer and flags; a new character wins over a clearing read.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {rxf_r, nf_r, fe_r, bkf_r, rx_arm_r, rx9_r} <= 6'h00;
      rxdata_r <= 8'h00;
    end else if (ce_i) begin
      if (rd_w && paddr_i == ADDR_STAT1) begin
        rx_arm_r <= 1'b1;
      end else if (rd_w && paddr_i == ADDR_DATA) begin
        rx_arm_r <= 1'b0;
      end
      if (rd_w && paddr_i == ADDR_DATA && rx_arm_r) begin
        {rxf_r, nf_r, fe_r, bkf_r} <= 4'h0;
      end
      if (rx_done) begin
        rxf_r <= 1'b1;
        rxdata_r <= rx_data;
        rx9_r <= rx_ninth;
        fe_r <= rx_fe;
        nf_r <= rx_nf;
        bkf_r <= rx_brk;
      end
    end
  end

  // Bit timing of the transmitter: sixteen oversample ticks per bit.
  assign frame_len = char9_r ? FRAME9 : FRAME8;
  assign bit_end = os_tick && (sub_r == OS_LAST);
  assign char_end = bit_end && (tx_st_r != TX_IDLE) && (bit_r == frame_len - 4'h1);
  assign launch = (tx_st_r == TX_IDLE) || char_end;
  assign te_rise = tx_en_r & !te_prev_r;

  // Next character: break first, then a queued idle, then buffered data.
  always_comb begin
    tx_pick = TX_IDLE;
    if (tx_en_r && port_en_r) begin
      if (brk_r) begin
        tx_pick = TX_BRK;
      end else if (qidle_r) begin
        tx_pick = TX_PRE;
      end else if (!txe_r) begin
        tx_pick = TX_DATA;
      end
    end
  end

  // Transmit sequencer and shift register.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_st_r <= TX_IDLE;
      sub_r <= 4'h0;
      bit_r <= 4'h0;
      sh_r <= 11'h7ff;
    end else if (ce_i) begin
      if (!port_en_r) begin
        tx_st_r <= TX_IDLE;
      end else if (launch) begin
        tx_st_r <= tx_pick;
        sub_r <= 4'h0;
        bit_r <= 4'h0;
        case (tx_pick)
          TX_DATA: sh_r <= char9_r ? {1'b1, tx9_r, txbuf_r, 1'b0}
                                   : {2'b11, txbuf_r, 1'b0};
          TX_BRK: sh_r <= 11'h000;
          default: sh_r <= 11'h7ff;
        endcase
      end else if (os_tick) begin
        sub_r <= sub_r + 4'h1;
        if (bit_end) begin
          bit_r <= bit_r + 4'h1;
          sh_r <= {1'b1, sh_r[10:1]};
        end
      end
    end
  end

  // Queued idle: set by each rising enable while the port is on and after a break, taken by a preamble.
  // Enable rises too late for the current stop bit lose data, as software is warned.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qidle_r <= 1'b0;
      te_prev_r <= 1'b0;
    end else if (ce_i) begin
      te_prev_r <= tx_en_r;
      if (!port_en_r) begin
        qidle_r <= 1'b0;
      end else if (te_rise) begin
        qidle_r <= 1'b1;
      end else if (char_end && tx_st_r == TX_BRK && !brk_r) begin
        qidle_r <= 1'b1;
      end else if (launch && tx_pick == TX_PRE) begin
        qidle_r <= 1'b0;
      end
    end
  end

  // Transmit-empty: the load sets it even in the cycle software clears it.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txe_r <= 1'b1;
      tx_arm_r <= 1'b0;
      txd_r <= 1'b1;
    end else if (ce_i) begin
      if (rd_w && paddr_i == ADDR_STAT1) begin
        tx_arm_r <= 1'b1;
      end else if (wr_w && paddr_i == ADDR_DATA) begin
        tx_arm_r <= 1'b0;
      end
      if (port_en_r && launch && tx_pick == TX_DATA) begin
        txe_r <= 1'b1;
      end else if (wr_w && paddr_i == ADDR_DATA && tx_arm_r) begin
        txe_r <= 1'b0;
      end
      txd_r <= (tx_st_r == TX_IDLE) && txe_r && !qidle_r;
    end
  end

  // Pin drive: idle level outside characters, every level flipped by invert.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_pin_o <= 1'b1;
      tx_pin_oe_o <= 1'b0;
      rx_pin_claim_o <= 1'b0;
    end else if (ce_i) begin
      tx_pin_o <= ((tx_st_r == TX_IDLE) ? 1'b1 : sh_r[0]) ^ tx_inv_r;
      tx_pin_oe_o <= port_en_r;
      rx_pin_claim_o <= port_en_r & rx_en_r;
    end
  end

  // Interrupt requests are plain levels of flag and enable.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
    end else if (ce_i) begin
      tx_irq_o <= (txe_r & txe_ie_r) | (txd_r & txd_ie_r);
      rx_irq_o <= rxf_r & rxf_ie_r;
    end
  end

endmodule : astrc_core

`default_nettype wire

// ===== testbench/astrc_core_sva.sv
// Port-level checks for the serial core, bound to its top module.
// Assumes one clock domain with an asynchronous active-low reset.
`default_nettype none
module astrc_core_sva (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_o,
  input wire logic rx_pin_claim_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o
);
  logic [3:0] hist_r;
  logic [4:0] run_r;
  logic pin_r;
  logic quiet;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Outputs may move only a few clocks after a completed access.
  assign quiet = !(|hist_r);
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hist_r <= 4'h0;
    end else begin
      hist_r <= {hist_r[2:0], psel_i & penable_i & pready_o};
    end
  end
  // Cycles since the line last moved; saturates so long idles stay cheap.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_r <= 1'b1;
      run_r <= 5'h00;
    end else begin
      pin_r <= tx_pin_o;
      run_r <= (tx_pin_o != pin_r) ? 5'h00 : run_r + 5'(run_r != 5'h1f);
    end
  end
  sequence s_hold8;
    $stable(tx_pin_o) [*8];
  endsequence
  chk_oe_by_write: assert property ($changed(tx_pin_oe_o) |-> !quiet)
    else $error("pin enable moved without an access");
  chk_claim_write: assert property ($changed(rx_pin_claim_o) |-> !quiet)
    else $error("receive claim moved without an access");
  chk_claim_needs_oe: assert property (rx_pin_claim_o |-> tx_pin_oe_o)
    else $error("receive claimed while port is off");
  chk_off_quiet: assert property (!tx_pin_oe_o && !$past(tx_pin_oe_o) && quiet
    |-> $stable(tx_pin_o)) else $error("released pin still toggling");
  chk_enable_idle: assert property ($rose(tx_pin_oe_o) |=> s_hold8)
    else $error("line not idle after enable");
  chk_tx_bit_len: assert property ($changed(tx_pin_o) && $past(tx_pin_oe_o)
    && tx_pin_oe_o && quiet |-> run_r >= 5'h0f) else $error("bit shorter than 16 ticks");
  chk_rx_irq_clear: assert property ($fell(rx_irq_o) |-> !quiet)
    else $error("receive request dropped on its own");
  chk_tx_irq_clear: assert property ($fell(tx_irq_o) |-> !quiet)
    else $error("transmit request dropped on its own");
endmodule : astrc_core_sva
`default_nettype wire

// ===== testbench/astrc_peer.sv
// Remote serial device: drives the receive line and decodes the transmit line.
// Assumes sixteen clocks per bit; its line idles high, as with a pull-up.
`default_nettype none
module astrc_peer (
  input wire logic clock_i,
  input wire logic tx_pin_i,
  output logic rx_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_pin_o = 1'b1;
  end
  // Sends n bits LSB first; g inverts the line for one clock to mimic noise.
  task automatic send(input logic [11:0] f, input int n, input int g);
    for (int i = 0; i < n * 16; i++) begin
      rx_pin_o <= f[i / 16] ^ (i == g);
      @(posedge clock_i);
    end
    rx_pin_o <= 1'b1;
    @(posedge clock_i);
  endtask : send
  // Waits w clocks at most for a start level; all ones back means none came.
  task automatic recv(input int n, input logic inv, input int w, output logic [10:0] f);
    f = 11'h7ff;
    while (tx_pin_i === ~inv && w > 0) begin
      w--;
      @(posedge clock_i);
    end
    if (w > 0) begin
      repeat (8) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
        f[i] = tx_pin_i ^ inv;
        repeat (16) @(posedge clock_i);
      end
    end
  endtask : recv
endmodule : astrc_peer
`default_nettype wire

// ===== testbench/astrc_core_tb.sv
// Self-checking bench for the serial core over APB with a remote peer.
// Assumes the reset divisor of one, so a bit lasts sixteen clocks.
`default_nettype none
module astrc_core_tb;
  import astrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0, nrst_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic prdy, perr, txp, txoe, claim, tirq, rirq, rxp;
  int fail_count = 0, check_count = 0, cyc = 0;
  astrc_core uut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .rx_pin_i(rxp), .baud_ext_i(1'b0), .tx_pin_o(txp),
    .tx_pin_oe_o(txoe), .rx_pin_claim_o(claim), .tx_irq_o(tirq), .rx_irq_o(rirq));
  astrc_peer peer (.clock_i(clock_i), .tx_pin_i(txp), .rx_pin_o(rxp));
  // Clock and a ceiling well above the expected run length.
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tk
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high, then an idle cycle.
  // The error answer is folded into rd[31]; no mapped register uses that bit.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (prdy !== 1'b1);
    rd = prd | {perr, 31'h0};
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task automatic t_tx8();
    logic [10:0] f;
    apb(1'b1, ADDR_DATA, 32'h5a);
    apb(1'b0, ADDR_STAT1, 32'h0);
    chk(rd, 32'hc0);
    apb(1'b1, ADDR_CTRL1, 32'h40);
    apb(1'b1, ADDR_CTRL2, 32'h08);
    apb(1'b0, ADDR_CTRL2, 32'h0);
    chk({rd[30:0], txoe}, 32'h11);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h8000_0000);
    peer.recv(10, 1'b0, 400, f);
    chk(32'(f), 32'h7ff);
    apb(1'b0, ADDR_STAT1, 32'h0);
    apb(1'b1, ADDR_DATA, 32'ha5);
    peer.recv(10, 1'b0, 400, f);
    chk(32'(f), 32'h74a);
    apb(1'b0, ADDR_STAT1, 32'h0);
    chk(rd, 32'hc0);
    apb(1'b1, ADDR_CTRL2, 32'h48);
    tk(1);
    chk(32'(tirq), 32'h1);
    apb(1'b1, ADDR_CTRL2, 32'h08);
  endtask : t_tx8
  // Nine bits with the line inverted, ninth bit held at zero.
  task automatic t_tx9i();
    logic [10:0] f;
    apb(1'b1, ADDR_CTRL1, 32'h70);
    apb(1'b1, ADDR_CTRL3, 32'h0);
    chk(32'(txp), 32'h0);
    apb(1'b0, ADDR_STAT1, 32'h0);
    apb(1'b1, ADDR_DATA, 32'h3c);
    peer.recv(11, 1'b1, 400, f);
    chk(32'(f), 32'h478);
    apb(1'b1, ADDR_CTRL1, 32'h40);
  endtask : t_tx9i
  task automatic t_brk();
    int n;
    apb(1'b1, ADDR_CTRL2, 32'h09);
    tk(300);
    chk(32'(txp), 32'h0);
    apb(1'b1, ADDR_CTRL2, 32'h08);
    n = 0;
    while (txp !== 1'b1 && n < 400) begin
      n++;
      tk(1);
    end
    tk(15);
    chk(32'(txp), 32'h1);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    tk(1);
    chk(32'({txoe, claim}), 32'h0);
  endtask : t_brk
  // One received frame; flags are read before the status-then-data clear.
  task automatic rx1(input logic c9, input logic [11:0] fr, input int g,
      input logic [7:0] d, input logic [31:0] s1, input logic [1:0] nb);
    apb(1'b1, ADDR_CTRL1, 32'h40 | (32'(c9) << 4));
    peer.send(fr, 10 + int'(c9), g);
    tk(4);
    chk(32'(rirq), 32'h1);
    apb(1'b0, ADDR_STAT2, 32'h0);
    chk(32'(rd[S2_BRK]), 32'(nb[0]));
    apb(1'b0, ADDR_CTRL3, 32'h0);
    chk(32'(rd[C3_RX9]), 32'(nb[1]));
    apb(1'b0, ADDR_STAT1, 32'h0);
    chk(rd & 32'h26, s1);
    apb(1'b0, ADDR_DATA, 32'h0);
    chk(rd, 32'(d));
    tk(1);
    chk(32'(rirq), 32'h0);
  endtask : rx1
  task automatic t_rx();
    apb(1'b1, ADDR_CTRL1, 32'h40);
    apb(1'b1, ADDR_CTRL2, 32'h24);
    tk(1);
    chk(32'(claim), 32'h1);
    peer.send(12'h001, 1, 0);
    tk(200);
    apb(1'b0, ADDR_STAT1, 32'h0);
    chk(rd & 32'h20, 32'h0);
    rx1(1'b0, 12'h32c, -1, 8'h96, 32'h20, 2'b10);
    rx1(1'b1, 12'h6aa, -1, 8'h55, 32'h20, 2'b10);
    rx1(1'b0, 12'h32c, 56, 8'h96, 32'h24, 2'b10);
    rx1(1'b0, 12'h000, -1, 8'h00, 32'h22, 2'b01);
    rx1(1'b0, 12'h0b4, -1, 8'h5a, 32'h22, 2'b00);
  endtask : t_rx
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    tk(6);
    nrst_i <= 1'b1;
    tk(1);
    t_tx8();
    t_tx9i();
    t_brk();
    t_rx();
    complete_run();
  end
endmodule : astrc_core_tb
bind astrc_core astrc_core_sva u_sva (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
  .rx_pin_claim_o(rx_pin_claim_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
`default_nettype wire
